// ==== logic/perg_len_calc.sv ====
/*
  Length of a response in 16-bit words from command opcode and read count.
  Assumes a purely combinational context.
*/
`timescale 1ns/1ps
`default_nettype none
`include "perg_map.svh"
module perg_len_calc
  import perg_pkg::*;
(
  input  wire logic [3:0]  i_cmd,
  input  wire logic [15:0] i_count,
  output logic      [16:0] o_len
);
  logic [16:0] pairs;
  logic [17:0] three;
  always_comb
  begin
    pairs = {1'b0, i_count} + {16'h0000, i_count[0]};
    three = {pairs, 1'b0} + {1'b0, pairs};
    if (i_cmd == `PERG_CMD_READ)
      o_len = three[17:1] + {1'b0, `PERG_LEN_HDR};
    else
      o_len = {1'b0, `PERG_LEN_HDR};
  end
endmodule // perg_len_calc
`default_nettype wire

// ==== logic/perg_resp_gen.sv ====
/*
  Response generator of a programming executive: header words, length and
  packed read data words forwarded from the memory side.
  Assumes the command decoder presents one completed command with its outcome,
  and a source of packed read words with valid/ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "perg_map.svh"
module perg_resp_gen
  import perg_pkg::*;
#(
  parameter logic [7:0] VERSION_BYTE = 8'h10 // Arbitrary default version
)
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_cmd_valid,
  output logic             o_cmd_ready,
  input  wire logic [3:0]  i_cmd_opcode,
  input  wire logic        i_cmd_known,
  input  wire logic        i_cmd_ok,
  input  wire logic        i_verify_fail,
  input  wire logic        i_blank,
  input  wire logic [15:0] i_read_count,
  input  wire logic        i_rd_valid,
  output logic             o_rd_ready,
  input  wire logic [15:0] i_rd_data,
  output logic             o_rsp_valid,
  input  wire logic        i_rsp_ready,
  output logic      [15:0] o_rsp_data,
  output logic             o_rsp_last,
  output logic             o_busy
);
  perg_state_t  state;
  perg_state_t  next_state;
  logic [15:0]  hdr0;
  logic [15:0]  hdr1;
  logic [16:0]  remain;
  logic [16:0]  calc_len;
  logic [3:0]   rsp_opc;
  logic [7:0]   rsp_qe;
  logic         take;
  logic         fire;
  perg_word_if  out_if ();

  perg_len_calc u_len
  (
    .i_cmd   (i_cmd_opcode),
    .i_count (i_read_count),
    .o_len   (calc_len)
  );

  // ----------------------------------------------------------------
  // Header composition
  // ----------------------------------------------------------------
  always_comb
  begin
    rsp_opc = `PERG_RSP_PASS;
    rsp_qe  = `PERG_QE_OK;
    if (!i_cmd_known)
    begin
      rsp_opc = `PERG_RSP_UNKNOWN_COMMAND_REPLY;
      rsp_qe  = `PERG_QE_OTHER;
    end
    else if (i_cmd_opcode == `PERG_CMD_BLANK)
      rsp_qe = i_blank ? `PERG_QE_BLANK : `PERG_QE_NOTBLANK;
    else if (i_cmd_opcode == `PERG_CMD_VERSION)
      rsp_qe = VERSION_BYTE;
    else if (!i_cmd_ok)
    begin
      rsp_opc = `PERG_RSP_FAIL;
      if (i_verify_fail && (i_cmd_opcode == `PERG_CMD_ROWPROG || i_cmd_opcode == `PERG_CMD_UIDPROG))
        rsp_qe = `PERG_QE_VERIFY;
      else
        rsp_qe = `PERG_QE_OTHER;
    end
  end

  assign take        = (state == PERG_IDLE) && i_cmd_valid;
  assign o_cmd_ready = (state == PERG_IDLE);
  assign fire        = out_if.valid && out_if.ready;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      PERG_IDLE: if (take) next_state = PERG_HDR0;
      PERG_HDR0: if (fire) next_state = PERG_HDR1;
      PERG_HDR1: if (fire) next_state = (remain == 17'h00000) ? PERG_IDLE : PERG_DATA;
      PERG_DATA: if (fire && remain == 17'h00001) next_state = PERG_IDLE;
      default:   next_state = PERG_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      state <= PERG_IDLE;
    else if (i_ce)
      state <= next_state;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hdr0 <= 16'h0000;
      hdr1 <= 16'h0000;
    end
    else if (i_ce && take)
    begin
      hdr0[`PERG_OPC_HI:`PERG_OPC_LO] <= rsp_opc;
      hdr0[`PERG_CMD_HI:`PERG_CMD_LO] <= i_cmd_opcode;
      hdr0[`PERG_QE_HI:`PERG_QE_LO]   <= rsp_qe;
      hdr1 <= (rsp_opc == `PERG_RSP_PASS) ? calc_len[15:0] : `PERG_LEN_HDR;
    end
  end

  // Data words still owed after the header
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      remain <= 17'h00000;
    else if (i_ce)
    begin
      if (take)
        remain <= (rsp_opc == `PERG_RSP_PASS) ? (calc_len - {1'b0, `PERG_LEN_HDR}) : 17'h00000;
      else if (state == PERG_DATA && fire)
        remain <= remain - 17'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Output stream
  // ----------------------------------------------------------------
  always_comb
  begin
    out_if.valid = 1'b0;
    out_if.data  = 16'h0000;
    out_if.last  = 1'b0;
    case (state)
      PERG_HDR0:
      begin
        out_if.valid = 1'b1;
        out_if.data  = hdr0;
      end
      PERG_HDR1:
      begin
        out_if.valid = 1'b1;
        out_if.data  = hdr1;
        out_if.last  = (remain == 17'h00000);
      end
      PERG_DATA:
      begin
        out_if.valid = i_rd_valid;
        out_if.data  = i_rd_data;
        out_if.last  = (remain == 17'h00001);
      end
      default:
      begin
        out_if.valid = 1'b0;
      end
    endcase
  end

  assign out_if.ready = i_rsp_ready && i_ce;
  assign o_rsp_valid  = out_if.valid;
  assign o_rsp_data   = out_if.data;
  assign o_rsp_last   = out_if.last;
  assign o_rd_ready   = (state == PERG_DATA) && out_if.ready;
  assign o_busy       = (state != PERG_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] cap_cmd;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cap_cmd <= 4'h0;
    else if (i_ce && take)
      cap_cmd <= i_cmd_opcode;
  end

  AST_HDR_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce) |=> state == PERG_HDR0)
    else $error("No header after command");
  AST_NO_TAKE_BUSY: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_busy |-> !o_cmd_ready)
    else $error("Command accepted while busy");
  AST_BLANK_HDR: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_opcode == `PERG_CMD_BLANK && i_blank) |=> hdr0 == 16'h1af0)
    else $error("Blank header wrong");
  AST_NOTBLANK_HDR: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_opcode == `PERG_CMD_BLANK && !i_blank) |=> hdr0 == 16'h1a0f)
    else $error("Not blank header wrong");
  AST_VER_HDR: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_opcode == `PERG_CMD_VERSION) |=> hdr0 == {8'h1b, VERSION_BYTE} && hdr1 == 16'h0002)
    else $error("Version reply wrong");
  AST_UNKNOWN_COMMAND_REPLY: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && !i_cmd_known) |=> hdr0[15:12] == 4'h3 && remain == 17'h00000)
    else $error("Unknown command not refused");
  AST_ECHO: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state == PERG_HDR0) |-> hdr0[11:8] == cap_cmd)
    else $error("Echo field mismatch");
  AST_VERIFY_CODE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && !i_cmd_ok && i_verify_fail && i_cmd_opcode == `PERG_CMD_ROWPROG)
    |=> hdr0 == 16'h2501)
    else $error("Verify failure code wrong");
  AST_TWO_WORD: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_opcode != `PERG_CMD_READ) |=> hdr1 == 16'h0002)
    else $error("Non read reply not two words");
  AST_READ_LEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_ok && i_cmd_opcode == `PERG_CMD_READ && i_read_count == 16'h0003)
    |=> hdr1 == 16'h0008)
    else $error("Read length wrong");
  AST_LAST_ENDS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_rsp_valid && o_rsp_last && i_rsp_ready && i_ce) |=> state == PERG_IDLE)
    else $error("Last word did not end reply");

  // ----------------------------------------------------------------
  // Header field and stream checks
  // ----------------------------------------------------------------
  AST_FAIL_OPC: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && !i_cmd_ok && i_cmd_opcode != `PERG_CMD_BLANK
     && i_cmd_opcode != `PERG_CMD_VERSION) |=> hdr0[15:12] == 4'h2)
    else $error("Failure opcode missing");

  AST_OTHER_CODE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && !i_cmd_ok && !i_verify_fail && i_cmd_opcode != `PERG_CMD_BLANK
     && i_cmd_opcode != `PERG_CMD_VERSION) |=> hdr0[7:0] == 8'h02)
    else $error("Other error code wrong");

  AST_OK_CODE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_ok && i_cmd_opcode != `PERG_CMD_BLANK
     && i_cmd_opcode != `PERG_CMD_VERSION) |=> hdr0[15:12] == 4'h1 && hdr0[7:0] == 8'h00)
    else $error("Success header wrong");

  AST_UID_VERIFY: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && !i_cmd_ok && i_verify_fail && i_cmd_opcode == `PERG_CMD_UIDPROG)
    |=> hdr0 == 16'h2401)
    else $error("User id verify code wrong");

  AST_QUERY_PASS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && (i_cmd_opcode == `PERG_CMD_BLANK || i_cmd_opcode == `PERG_CMD_VERSION))
    |=> hdr0[15:12] == 4'h1)
    else $error("Query did not pass");

  AST_ECHO_TAKE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce)
    |=> hdr0[11:8] == $past(i_cmd_opcode))
    else $error("Echo not captured");

  AST_HDR0_STANDS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state == PERG_HDR0 && !fire)
    |=> state == PERG_HDR0 && o_rsp_data == $past(o_rsp_data))
    else $error("First word did not stand");

  AST_HDR1_NEXT: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state == PERG_HDR0 && fire)
    |=> state == PERG_HDR1 && o_rsp_valid && o_rsp_data == hdr1)
    else $error("Length word not second");

  AST_READ_EVEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_ok && i_cmd_opcode == `PERG_CMD_READ && i_read_count == 16'h0002)
    |=> hdr1 == 16'h0005)
    else $error("Even read length wrong");

  AST_READ_REMAIN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_ok && i_cmd_opcode == `PERG_CMD_READ && i_read_count == 16'h0003)
    |=> remain == 17'h00006)
    else $error("Read data count wrong");

  AST_FAIL_TWO: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && !i_cmd_ok && i_cmd_opcode != `PERG_CMD_BLANK
     && i_cmd_opcode != `PERG_CMD_VERSION) |=> hdr1 == 16'h0002 && remain == 17'h00000)
    else $error("Failure reply not two words");

  AST_UNKNOWN_COMMAND_REPLY_CODE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && !i_cmd_known)
    |=> hdr0[7:0] == 8'h02 && hdr1 == 16'h0002)
    else $error("Unknown reply fields wrong");

  AST_BLANK_LEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (take && i_ce && i_cmd_known && i_cmd_opcode == `PERG_CMD_BLANK)
    |=> hdr1 == 16'h0002)
    else $error("Blank reply length wrong");

  AST_IDLE_QUIET: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state == PERG_IDLE)
    |-> !o_rsp_valid)
    else $error("Word sent without command");

  AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_ce)
    |=> state == $past(state) && remain == $past(remain))
    else $error("State moved while frozen");

  AST_RD_IN_DATA: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rd_ready
    |-> state == PERG_DATA)
    else $error("Read word taken outside data phase");

  AST_LAST_NOT_FIRST: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_rsp_valid && o_rsp_last)
    |-> state != PERG_HDR0)
    else $error("Reply ended at first word");

  COV_VERSION: cover property (@(posedge i_clk) disable iff (!i_nrst)
    take && i_cmd_known && i_cmd_opcode == `PERG_CMD_VERSION);
  COV_FAIL: cover property (@(posedge i_clk) disable iff (!i_nrst)
    take && i_cmd_known && !i_cmd_ok);
  COV_BLANK: cover property (@(posedge i_clk) disable iff (!i_nrst)
    take && i_cmd_opcode == `PERG_CMD_BLANK);
  COV_UNKNOWN_COMMAND_REPLY: cover property (@(posedge i_clk) disable iff (!i_nrst) take && !i_cmd_known);
  COV_READ: cover property (@(posedge i_clk) disable iff (!i_nrst) state == PERG_DATA && fire);
endmodule // perg_resp_gen
`default_nettype wire

// ==== pkg/perg_map.svh ====
/*
  Constants of the executive response generator: opcodes, codes, field positions.
  Assumes inclusion by bare name from the modules.
*/
`ifndef PERG_MAP_SVH
`define PERG_MAP_SVH
`define PERG_RSP_PASS      4'h1
`define PERG_RSP_FAIL      4'h2
`define PERG_RSP_UNKNOWN_COMMAND_REPLY      4'h3
`define PERG_CMD_BLANK     4'ha
`define PERG_CMD_VERSION   4'hb
`define PERG_CMD_READ      4'h2
`define PERG_CMD_ROWPROG   4'h5
`define PERG_CMD_UIDPROG   4'h4
`define PERG_QE_BLANK      8'hf0
`define PERG_QE_NOTBLANK   8'h0f
`define PERG_QE_OK         8'h00
`define PERG_QE_VERIFY     8'h01
`define PERG_QE_OTHER      8'h02
`define PERG_LEN_HDR       16'h0002
`define PERG_OPC_HI        15
`define PERG_OPC_LO        12
`define PERG_CMD_HI        11
`define PERG_CMD_LO        8
`define PERG_QE_HI         7
`define PERG_QE_LO         0
`endif

// ==== pkg/perg_pkg.sv ====
/*
  Types of the executive response generator.
  Assumes perg_map.svh on the include path.
*/
package perg_pkg;
  typedef enum logic [1:0]
  {
    PERG_IDLE = 2'b00,
    PERG_HDR0 = 2'b01,
    PERG_HDR1 = 2'b10,
    PERG_DATA = 2'b11
  } perg_state_t;
endpackage

// ==== pkg/perg_word_if.sv ====
/*
  Carrier for one word stream with valid/ready handshake.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface perg_word_if;
  logic        valid;
  logic        ready;
  logic [15:0] data;
  logic        last;
  modport src (output valid, output data, output last, input ready);
  modport dst (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// ==== verif/perg_prog_model.sv ====
/*
  Programmer model: takes every reply word, either at once or with stalls.
  Assumes one clock shared with the response generator.
*/
`timescale 1ns/1ps
`default_nettype none
module perg_prog_model
(
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_rsp_valid,
  input  wire logic [15:0] i_rsp_data,
  input  wire logic        i_rsp_last,
  output logic             o_rsp_ready
);
  logic [16:0] words[$];
  logic        phase = 1'b0;

  initial o_rsp_ready = 1'b0;

  // ----------------------------------------
  // Ready toggles every cycle in slow mode
  // ----------------------------------------
  always @(negedge i_clk)
  begin
    phase       <= ~phase;
    o_rsp_ready <= ~i_slow | phase;
  end

  always @(posedge i_clk)
  begin
    if (i_rsp_valid && o_rsp_ready)
      words.push_back({i_rsp_last, i_rsp_data});
  end
endmodule // perg_prog_model
`default_nettype wire

// ==== verif/tb.sv ====
/*
  Testbench of the response generator: each task sends one kind of command (t_codes sends three)
  and compares the whole reply. Assumes perg_prog_model as reply consumer.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import perg_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [3:0]  op = 4'h0;
  logic        kn = 1'b0;
  logic        ok = 1'b0;
  logic        vf = 1'b0;
  logic        bl = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] rd_data = 16'h0000;
  logic [15:0] rd_idx = 16'h0000;
  logic        cmd_ready, rd_ready, rsp_valid, rsp_ready, rsp_last, busy;
  logic [15:0] rsp_data;
  logic [15:0] e[$];
  int          mismatches = 0;
  int          n_compared = 0;

  always #25 clk = ~clk;

  // ----------------------------------------
  // Packed read source, one new word per take
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rd_ready)
      rd_idx <= rd_idx + 16'h0001;
  end
  always @(negedge clk) rd_data <= 16'ha000 + rd_idx;

  perg_resp_gen #(.VERSION_BYTE(8'h23)) dut_u
  (
    .i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd_opcode(op), .i_cmd_known(kn), .i_cmd_ok(ok), .i_verify_fail(vf), .i_blank(bl),
    .i_read_count(cnt), .i_rd_valid(1'b1), .o_rd_ready(rd_ready), .i_rd_data(rd_data),
    .o_rsp_valid(rsp_valid), .i_rsp_ready(rsp_ready), .o_rsp_data(rsp_data),
    .o_rsp_last(rsp_last), .o_busy(busy)
  );

  perg_prog_model model_u
  (
    .i_clk(clk), .i_slow(slow), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
    .i_rsp_last(rsp_last), .o_rsp_ready(rsp_ready)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Flags are {known, ok, verify_fail, blank}; hold keeps a second request up while busy
  task automatic run_cmd(input logic [3:0] c, input logic [3:0] f, input int hold);
    int n;
    @(negedge clk);
    model_u.words.delete();
    {op, kn, ok, vf, bl, cmd_valid} = {c, f, 1'b1};
    @(negedge clk);
    chk("cmd_ready", {16'h0000, cmd_ready}, 17'h0);
    {op, kn} = {4'h9, 1'b0};
    repeat (hold) @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 2000 && (busy !== 1'b0 || rsp_valid !== 1'b0); n++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk("length", 17'(model_u.words.size()), 17'(e.size()));
    foreach (e[i]) chk("word", model_u.words[i], {i == e.size() - 1, e[i]});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_blank;
    slow = 1'b0;
    e = {16'h1af0, 16'h0002};
    run_cmd(4'ha, 4'b1101, 0);
    e = {16'h1a0f, 16'h0002};
    run_cmd(4'ha, 4'b1100, 0);
    $display("test blank done");
  endtask

  task automatic t_version;
    slow = 1'b1;
    e = {16'h1b23, 16'h0002};
    run_cmd(4'hb, 4'b1100, 0);
    $display("test version done");
  endtask

  task automatic t_codes;
    logic [3:0]  c[5] = '{4'h5, 4'h5, 4'h4, 4'h5, 4'h2};
    logic [3:0]  f[5] = '{4'b1100, 4'b1010, 4'b1010, 4'b1000, 4'b1000};
    logic [15:0] h[5] = '{16'h1500, 16'h2501, 16'h2401, 16'h2502, 16'h2202};
    slow = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      e = {h[i], 16'h0002};
      run_cmd(c[i], f[i], 0);
    end
    $display("test codes done");
  endtask

  task automatic t_unknown;
    slow = 1'b1;
    e = {16'h3702, 16'h0002};
    run_cmd(4'h7, 4'b0000, 3);
    $display("test unknown done");
  endtask

  task automatic t_read;
    slow = 1'b1;
    for (int n = 2; n < 4; n++)
    begin
      cnt = 16'(n);
      e = {16'h1200, 16'(3 * ((n + 1) / 2) + 2)};
      for (int i = 0; i < 3 * ((n + 1) / 2); i++) e.push_back(16'ha000 + rd_idx + 16'(i));
      run_cmd(4'h2, 4'b1100, 0);
    end
    $display("test read done");
  endtask

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_blank();
    t_version();
    t_codes();
    t_unknown();
    t_read();
    finish_test();
  end

  initial
  begin
    #1000000;
    mismatches++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
